/* File: common/wdt_pkg.sv */
package wdt_pkg;
  // Register offsets on the device interface
  localparam logic [1:0] WDC_OFS   = 2'h0;
  localparam logic [1:0] FLAGS_OFS = 2'h1;
  localparam logic [1:0] LVT_OFS   = 2'h2;
  localparam logic [1:0] STAT_OFS  = 2'h3;
  // Reset values
  localparam logic [7:0] WDC_RST   = 8'h53;
  localparam logic [7:0] LVT_RST   = 8'h55;
  // Valid guard codes
  localparam logic [4:0] WD_CODE_A = 5'h0a;
  localparam logic [4:0] WD_CODE_B = 5'h15;
  localparam logic [7:0] LV_CODE_A = 8'h55;
  localparam logic [7:0] LV_CODE_B = 8'h33;
  localparam logic [7:0] LV_CODE_C = 8'h99;
  localparam logic [7:0] LV_CODE_D = 8'haa;
  // Flags register field positions
  localparam int FL_WRF   = 0;
  localparam int FL_LRF   = 1;
  localparam int FL_UNDERVOLTAGE_RESET_FLAG  = 2;
  localparam int FL_HIRC  = 4;
  localparam int FL_FSYS  = 7;
  localparam logic [7:0] FL_WMASK = 8'hb7;
  // Status register field positions
  localparam int ST_PDF   = 0;
  localparam int ST_TO    = 1;
  // Debounce in subclock ticks (2 to 3 edges)
  localparam int DEBOUNCE_TICKS = 2;
  // Controller register map
  localparam logic [3:0] C_CMD    = 4'h0;
  localparam logic [3:0] C_WDATA  = 4'h1;
  localparam logic [3:0] C_RDATA  = 4'h2;
  localparam logic [3:0] C_ISTAT  = 4'h3;
  localparam logic [3:0] C_IMASK  = 4'h4;
  localparam logic [3:0] C_STATE  = 4'h5;
  // Command bits
  localparam int CMD_CLR  = 0;
  localparam int CMD_HALT = 1;
  localparam int CMD_WR   = 2;
  localparam int CMD_RD   = 3;
  localparam int CMD_WAKE = 4;
  localparam logic [7:0] FL_RSTVAL = 8'h00;
endpackage

/* File: common/wdt_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface wdt_if;
  logic       sub_tick;
  logic       clr_wd;
  logic       halt;
  logic       wake;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       uv_qual;
  logic       sys_reset;
  logic       pc_sp_clear;
  logic       timeout_flag;
  logic       power_down_flag;
  logic       halted;
  modport dev (input sub_tick, clr_wd, halt, wake, addr, wdata, wr, rd, uv_qual,
               output rdata, sys_reset, pc_sp_clear, timeout_flag, power_down_flag, halted);
  modport core (output clr_wd, halt, wake, addr, wdata, wr, rd,
                input rdata, sys_reset, pc_sp_clear, timeout_flag, power_down_flag, halted,
                sub_tick, uv_qual);
endinterface
`default_nettype wire

/* File: logic/wdt_dev.sv */
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Counter steps on subclock, also while halted
// - Select field picks 2^8 to 2^18 period
// - Only two enable codes keep watchdog running
// - Bad enable code resets after debounce
// - Bad enable code reset sets wd flag
// - Wd code flag set by hardware only
// - Reset loads 0x53; halted timeout keeps it
// - Running overflow resets and sets timeout flag
// - Halted overflow sets flag, clears PC/SP only
// - Code reset, clear, halt clear counter
// - Qualified undervoltage resets, sets its flag
// - Four threshold codes valid, else reset
// - Bad threshold code sets its flag
// - Undervoltage flag cleared only by software
// - Power-on zeroes PC, pins become inputs
// - Flags bits 6 and 3 read zero
// - Power-down flag: set by halt, clear by clear
// - Halted timeout leaves both flags one
module wdt_dev
  import wdt_pkg::*;
#(
  parameter int CNT_W = 18
) (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  wdt_if.dev        bus
);
  logic [7:0]       wdc_q;
  logic [7:0]       lvt_q;
  logic             wrf_q, lrf_q, undervoltage_reset_flag_q, fsys_q;
  logic [1:0]       hirc_q;
  logic             to_q, pdf_q, halted_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0]       wd_deb_q, lv_deb_q;
  logic             sys_reset_q, pcsp_q;
  logic             wd_bad, lv_bad, wd_fire, lv_fire, ovf, soft_rst;
  logic [7:0]       rdata_q;

  function automatic logic lv_ok(input logic [7:0] c);
    lv_ok = (c == LV_CODE_A) || (c == LV_CODE_B) || (c == LV_CODE_C) || (c == LV_CODE_D);
  endfunction

  assign wd_bad  = !(wdc_q[7:3] == WD_CODE_A || wdc_q[7:3] == WD_CODE_B);
  assign lv_bad  = !lv_ok(lvt_q);
  assign wd_fire = wd_bad && bus.sub_tick && (wd_deb_q == 2'(DEBOUNCE_TICKS));
  assign lv_fire = lv_bad && bus.sub_tick && (lv_deb_q == 2'(DEBOUNCE_TICKS));
  // Overflow when all selected bits are ones on a tick
  always_comb begin
    logic [4:0] sh;
    sh = 5'd0;
    case (wdc_q[2:0])
      3'd0: sh = 5'd8;
      3'd1: sh = 5'd10;
      3'd2: sh = 5'd12;
      3'd3: sh = 5'd14;
      default: sh = 5'(5'd11 + {2'b00, wdc_q[2:0]});
    endcase
    ovf = bus.sub_tick && !wd_bad && (cnt_q == CNT_W'(({{(CNT_W-1){1'b0}}, 1'b1} << sh) - 1));
  end
  // A full reset reloads control registers, counters and halt state; timeout and power-down flags keep their values
  assign soft_rst = wd_fire || lv_fire || bus.uv_qual || (ovf && !halted_q);

  // Debounce counters on subclock ticks
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wd_deb_q <= 2'd0;
      lv_deb_q <= 2'd0;
    end else begin
      if (!wd_bad || soft_rst) wd_deb_q <= 2'd0;
      else if (bus.sub_tick && wd_deb_q != 2'(DEBOUNCE_TICKS)) wd_deb_q <= wd_deb_q + 2'd1;
      if (!lv_bad || soft_rst) lv_deb_q <= 2'd0;
      else if (bus.sub_tick && lv_deb_q != 2'(DEBOUNCE_TICKS)) lv_deb_q <= lv_deb_q + 2'd1;
    end
  end

  // Watchdog counter, free running on the subclock
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
    end else if (soft_rst || bus.clr_wd || bus.halt || ovf) begin
      cnt_q <= '0;
    end else if (bus.sub_tick && !wd_bad) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Control registers; halted timeout leaves them alone
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdc_q  <= WDC_RST;
      lvt_q  <= LVT_RST;
      fsys_q <= 1'b0;
      hirc_q <= 2'b00;
    end else if (soft_rst) begin
      wdc_q  <= WDC_RST;
      lvt_q  <= LVT_RST;
      fsys_q <= 1'b0;
      hirc_q <= 2'b00;
    end else if (bus.wr) begin
      if (bus.addr == WDC_OFS) wdc_q <= bus.wdata;
      if (bus.addr == LVT_OFS) lvt_q <= bus.wdata;
      if (bus.addr == FLAGS_OFS) begin
        fsys_q <= bus.wdata[FL_FSYS];
        hirc_q <= bus.wdata[FL_HIRC+:2];
      end
    end
  end

  // Sticky reset cause flags, set wins over software clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wrf_q  <= 1'b0;
      lrf_q  <= 1'b0;
      undervoltage_reset_flag_q <= 1'b0;
    end else begin
      if (wd_fire) wrf_q <= 1'b1;
      else if (bus.wr && bus.addr == FLAGS_OFS && !bus.wdata[FL_WRF]) wrf_q <= 1'b0;
      if (lv_fire) lrf_q <= 1'b1;
      else if (bus.wr && bus.addr == FLAGS_OFS && !bus.wdata[FL_LRF]) lrf_q <= 1'b0;
      if (bus.uv_qual) undervoltage_reset_flag_q <= 1'b1;
      else if (bus.wr && bus.addr == FLAGS_OFS && !bus.wdata[FL_UNDERVOLTAGE_RESET_FLAG]) undervoltage_reset_flag_q <= 1'b0;
    end
  end

  // Timeout and power-down flags, halt state
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      to_q     <= 1'b0;
      pdf_q    <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      if (ovf) to_q <= 1'b1;
      else if (bus.clr_wd || bus.halt) to_q <= 1'b0;
      if (bus.halt) pdf_q <= 1'b1;
      else if (bus.clr_wd) pdf_q <= 1'b0;
      if (soft_rst || ovf || bus.wake) halted_q <= 1'b0;
      else if (bus.halt) halted_q <= 1'b1;
    end
  end

  // One-cycle reset pulses to the core
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sys_reset_q <= 1'b0;
      pcsp_q      <= 1'b0;
    end else begin
      sys_reset_q <= soft_rst;
      pcsp_q      <= ovf && halted_q;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        WDC_OFS:   rdata_q <= wdc_q;
        FLAGS_OFS: rdata_q <= {fsys_q, 1'b0, hirc_q, 1'b0, undervoltage_reset_flag_q, lrf_q, wrf_q};
        LVT_OFS:   rdata_q <= lvt_q;
        STAT_OFS:  rdata_q <= {5'd0, halted_q, to_q, pdf_q};
        default:   rdata_q <= 8'h00;
      endcase
    end
  end

  assign bus.rdata           = rdata_q;
  assign bus.sys_reset       = sys_reset_q;
  assign bus.pc_sp_clear     = pcsp_q;
  assign bus.timeout_flag    = to_q;
  assign bus.power_down_flag = pdf_q;
  assign bus.halted          = halted_q;
endmodule
`default_nettype wire

/* File: logic/wdt_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Core-side end: software commands become clear/halt instructions
// and register accesses; reset pulses from the device reach the core.
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  wdt_if.core             bus,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_irq,
  output logic      [15:0] o_pc,
  output logic      [7:0] o_port_dir
);
  logic [7:0]  wdata_q, devrd_q, istat_q, imask_q, rdata_q;
  logic [1:0]  dev_addr_q;
  logic        clr_q, halt_q, wake_q, wr_q, rd_q, rd_d1_q;
  logic [15:0] pc_q;
  logic [7:0]  dir_q;
  logic        cmd_wr;

  assign cmd_wr = i_wr && i_addr == C_CMD;

  // Commands issue one-cycle strobes toward the device
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clr_q <= 1'b0; halt_q <= 1'b0; wake_q <= 1'b0; wr_q <= 1'b0; rd_q <= 1'b0;
      dev_addr_q <= 2'd0;
    end else begin
      clr_q  <= cmd_wr && i_wdata[CMD_CLR];
      halt_q <= cmd_wr && i_wdata[CMD_HALT] && !i_wdata[CMD_CLR];
      wake_q <= cmd_wr && i_wdata[CMD_WAKE];
      wr_q   <= cmd_wr && i_wdata[CMD_WR];
      rd_q   <= cmd_wr && i_wdata[CMD_RD] && !i_wdata[CMD_WR];
      if (cmd_wr) dev_addr_q <= i_wdata[7:6];
    end
  end

  // Write data holding and device read capture
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wdata_q <= 8'h00; devrd_q <= 8'h00; rd_d1_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == C_WDATA) wdata_q <= i_wdata;
      rd_d1_q <= rd_q;
      if (rd_d1_q) devrd_q <= bus.rdata;
    end
  end

  // Reset causes: 0 sys reset, 1 halted timeout; set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      istat_q <= 8'h00; imask_q <= 8'h00;
    end else begin
      istat_q <= (istat_q & ~((i_wr && i_addr == C_ISTAT) ? i_wdata : 8'h00))
                 | {6'd0, bus.pc_sp_clear, bus.sys_reset};
      if (i_wr && i_addr == C_IMASK) imask_q <= i_wdata;
    end
  end

  // Program counter cleared by both resets; port directions set to 0xff by a full reset
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_q <= 16'h0000; dir_q <= 8'hff;
    end else if (bus.sys_reset) begin
      pc_q <= 16'h0000; dir_q <= 8'hff;
    end else if (bus.pc_sp_clear) begin
      pc_q <= 16'h0000;
    end else if (!bus.halted) begin
      pc_q <= pc_q + 16'h0001;
    end
  end

  // Register read port
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) rdata_q <= 8'h00;
    else if (i_rd) begin
      case (i_addr)
        C_WDATA: rdata_q <= wdata_q;
        C_RDATA: rdata_q <= devrd_q;
        C_ISTAT: rdata_q <= istat_q;
        C_IMASK: rdata_q <= imask_q;
        C_STATE: rdata_q <= {5'd0, bus.halted, bus.timeout_flag, bus.power_down_flag};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign bus.clr_wd  = clr_q;
  assign bus.halt    = halt_q;
  assign bus.wake    = wake_q;
  assign bus.wr      = wr_q;
  assign bus.rd      = rd_q;
  assign bus.addr    = dev_addr_q;
  assign bus.wdata   = wdata_q;
  assign o_rdata     = rdata_q;
  assign o_irq       = |(istat_q & imask_q);
  assign o_pc        = pc_q;
  assign o_port_dir  = dir_q;
endmodule
`default_nettype wire

/* File: verification/wdt_props.sv */
`timescale 1ns/1ns
`default_nettype none
// Watches the link between the core end and the device end
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       sub_tick,
  input wire logic       uv_qual,
  input wire logic       clr_wd,
  input wire logic       halt,
  input wire logic       rd,
  input wire logic [1:0] addr,
  input wire logic [7:0] rdata,
  input wire logic       sys_reset,
  input wire logic       pc_sp_clear,
  input wire logic       timeout_flag,
  input wire logic       power_down_flag,
  input wire logic       halted
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Halt entry and the wake by a halted overflow
  sequence s_halt_entered;
    ##[1:3] (halted && power_down_flag && !timeout_flag);
  endsequence
  sequence s_halt_woken;
    ##[0:2] (timeout_flag && power_down_flag && !halted);
  endsequence
  halt_entry_a: assert property (halt |-> s_halt_entered)
    else $error("halt did not enter power down");
  halted_wake_a: assert property (pc_sp_clear |-> s_halt_woken)
    else $error("halted timeout flags wrong");
  clear_pdf_a: assert property (clr_wd |-> ##[1:3] !power_down_flag)
    else $error("clear left power down flag");
  no_full_halted_a: assert property (pc_sp_clear |-> !sys_reset)
    else $error("full reset during halted timeout");
  reset_pulse_a: assert property (sys_reset |=> !sys_reset)
    else $error("reset pulse too long");
  // A full reset always follows a subclock tick or a qualified undervoltage
  reset_cause_a: assert property (sys_reset |-> ($past(sub_tick, 2) || $past(sub_tick)
    || $past(uv_qual) || $past(uv_qual, 2) || $past(uv_qual, 3))) else $error("reset without cause");
  flags_gaps_a: assert property ($past(rd) && $past(addr) == FLAGS_OFS |-> rdata[6] == 1'b0
    && rdata[3] == 1'b0) else $error("unimplemented flag bits set");
  status_read_a: assert property ($past(rd) && $past(addr) == STAT_OFS |->
    rdata[ST_TO] == $past(timeout_flag) && rdata[ST_PDF] == $past(power_down_flag))
    else $error("status read differs from flags");
endmodule
`default_nettype wire

/* File: verification/tb_watchdog_and_reset_sources.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_watchdog_and_reset_sources
  import wdt_pkg::*;
;
  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [7:0]  o_rdata;
  logic        o_irq;
  logic [15:0] o_pc;
  logic [7:0]  o_port_dir;
  logic [1:0]  div = 2'h0;
  logic [7:0]  v;
  logic [7:0]  codes [4] = '{LV_CODE_A, LV_CODE_B, LV_CODE_C, LV_CODE_D};
  int          ticks = 0;
  int          hit = 0;
  int          miscompares = 0;
  int          tests_run = 0;
  wdt_if bus_if ();
  wdt_dev u_wdt_dev (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .bus(bus_if));
  wdt_core u_wdt_core (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .bus(bus_if), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_pc(o_pc), .o_port_dir(o_port_dir));
  wdt_checker u_wdt_checker (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .sub_tick(bus_if.sub_tick),
    .uv_qual(bus_if.uv_qual), .clr_wd(bus_if.clr_wd), .halt(bus_if.halt), .rd(bus_if.rd), .addr(bus_if.addr),
    .rdata(bus_if.rdata), .sys_reset(bus_if.sys_reset), .pc_sp_clear(bus_if.pc_sp_clear),
    .timeout_flag(bus_if.timeout_flag), .power_down_flag(bus_if.power_down_flag), .halted(bus_if.halted));
  // 100 ns system clock
  always #50 i_sys_clk = ~i_sys_clk;
  // Subclock edge every fourth cycle, never paused by halt
  always @(posedge i_sys_clk) begin
    div <= div + 2'h1;
    bus_if.sub_tick <= (div == 2'h2);
  end
  // Ticks since the last clear, halt, device write or reset
  always @(posedge i_sys_clk) begin
    if (bus_if.clr_wd || bus_if.halt || bus_if.wr || bus_if.sys_reset) begin
      ticks <= 0;
    end else if (bus_if.sub_tick) begin
      ticks <= ticks + 1;
    end
  end
  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle strobes with a gap, so no strobe is driven twice in a step
  task automatic cwr(input logic [3:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic crd(input logic [3:0] a, output logic [7:0] d);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    d = o_rdata;
    @(posedge i_sys_clk);
  endtask
  task automatic dwr(input logic [1:0] a, input logic [7:0] d);
    cwr(C_WDATA, d);
    cwr(C_CMD, {a, 6'h04});
    repeat (2) @(posedge i_sys_clk);
  endtask
  task automatic drd(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    cwr(C_CMD, {a, 6'h08});
    repeat (3) @(posedge i_sys_clk);
    crd(C_RDATA, v);
    chk(nm, v & m, e);
  endtask
  // Bounded wait for a full reset or a halted wake pulse; a timeout counts as a mismatch
  task automatic wait_ev(input bit full);
    int n;
    for (n = 0; n < 5000; n++) begin
      @(negedge i_sys_clk);
      if (full ? bus_if.sys_reset : bus_if.pc_sp_clear) begin
        hit = ticks;
        @(negedge i_sys_clk);
        chk("pc cleared", o_pc[15:8] | o_pc[7:0], 8'h00);
        break;
      end
    end
    if (n == 5000) begin
      miscompares++;
    end
    repeat (6) @(posedge i_sys_clk);
  endtask
  initial begin
    bus_if.uv_qual = 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    @(negedge i_sys_clk);
    chk("pc", o_pc[15:8] | o_pc[7:0], 8'h00);
    chk("port dir", o_port_dir, 8'hff);
    @(posedge i_sys_clk);
    drd(WDC_OFS, 8'hff, WDC_RST, "wdc");
    drd(LVT_OFS, 8'hff, LVT_RST, "lvt");
    dwr(FLAGS_OFS, 8'hf8);
    drd(FLAGS_OFS, 8'hff, 8'hb0, "flags gaps");
    dwr(FLAGS_OFS, 8'h00);
    // Running overflow: shortest period, first enable code
    dwr(WDC_OFS, 8'h50);
    cwr(C_CMD, 8'h01);
    repeat (800) @(posedge i_sys_clk);
    crd(C_ISTAT, v);
    chk("early reset", v & 8'h01, 8'h00);
    wait_ev(1'b1);
    chk("period", (hit == 256) ? 8'h01 : 8'h00, 8'h01);
    drd(STAT_OFS, 8'h02, 8'h02, "timeout flag");
    drd(WDC_OFS, 8'hff, WDC_RST, "wdc reload");
    // Second select code, four times the period
    dwr(WDC_OFS, 8'h51);
    cwr(C_CMD, 8'h01);
    wait_ev(1'b1);
    chk("period 1k", (hit == 1024) ? 8'h01 : 8'h00, 8'h01);
    // Halted overflow with the other enable code
    dwr(WDC_OFS, 8'ha8);
    cwr(C_CMD, 8'h02);
    wait_ev(1'b0);
    drd(STAT_OFS, 8'h07, 8'h03, "halted wake");
    drd(WDC_OFS, 8'hff, 8'ha8, "wdc kept");
    cwr(C_CMD, 8'h01);
    drd(STAT_OFS, 8'h01, 8'h00, "pdf clear");
    // Halt then wake command; power-down flag survives the wake
    cwr(C_CMD, 8'h02);
    crd(C_STATE, v);
    chk("halt state", v, 8'h05);
    cwr(C_CMD, 8'h10);
    crd(C_STATE, v);
    chk("wake state", v, 8'h01);
    cwr(C_CMD, 8'h01);
    // Corrupted enable code
    dwr(WDC_OFS, 8'h00);
    wait_ev(1'b1);
    chk("debounce", (hit == 2 || hit == 3) ? 8'h01 : 8'h00, 8'h01);
    drd(FLAGS_OFS, 8'h07, 8'h01, "wd code flag");
    dwr(FLAGS_OFS, 8'h00);
    drd(FLAGS_OFS, 8'h07, 8'h00, "wd flag clear");
    // Every valid threshold code stays put, a bad one resets
    foreach (codes[i]) begin
      dwr(LVT_OFS, codes[i]);
      drd(LVT_OFS, 8'hff, codes[i], "lvt code");
    end
    dwr(LVT_OFS, 8'h12);
    wait_ev(1'b1);
    drd(FLAGS_OFS, 8'h07, 8'h02, "lvt flag");
    // Undervoltage; the threshold flag must survive it
    bus_if.uv_qual <= 1'b1;
    @(posedge i_sys_clk);
    bus_if.uv_qual <= 1'b0;
    wait_ev(1'b1);
    drd(FLAGS_OFS, 8'h07, 8'h06, "uv flag");
    dwr(FLAGS_OFS, 8'h00);
    drd(FLAGS_OFS, 8'h07, 8'h00, "flags clear");
    // Interrupt raised, masked and cleared; a mask bit of one lets it through
    crd(C_ISTAT, v);
    chk("istat", v & 8'h03, 8'h03);
    cwr(C_IMASK, 8'h00);
    @(negedge i_sys_clk);
    chk("irq masked", {7'h00, o_irq}, 8'h00);
    @(posedge i_sys_clk);
    cwr(C_IMASK, 8'h03);
    @(negedge i_sys_clk);
    chk("irq unmasked", {7'h00, o_irq}, 8'h01);
    @(posedge i_sys_clk);
    cwr(C_ISTAT, 8'h03);
    crd(C_ISTAT, v);
    chk("istat clear", v & 8'h03, 8'h00);
    chk("irq low", {7'h00, o_irq}, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
